// ### hw/nvm_ctrl_pkg.sv
/*
 * Constants shared by the byte-wide nonvolatile access controller:
 * register offsets in the I/O space, control field positions, reset
 * values and timing counts.
 * Assumes a 40 MHz register clock and a 1 MHz timing oscillator.
 */
package nvm_ctrl_pkg;
   // Clock figures
   localparam int          CLK_PERIOD_NS      = 25;
   localparam int          OSC_FREQ_HZ        = 1000000;
   localparam int          WRITE_OSC_CYCLES   = 8448;
   localparam int          WRITE_TIME_US      =
      int'(64'(WRITE_OSC_CYCLES) * 64'd1000000 / OSC_FREQ_HZ);
   localparam int          WTIMER_W           = 14;

   // Array geometry
   localparam int          NVM_ADDR_W         = 11;
   localparam int          NVM_DATA_W         = 8;
   localparam int          IO_ADDR_W          = 6;

   // I/O offsets
   localparam logic [5:0]  OFS_ADDR_HI        = 6'h1F;
   localparam logic [5:0]  OFS_ADDR_LO        = 6'h1E;
   localparam logic [5:0]  OFS_DATA           = 6'h1D;
   localparam logic [5:0]  OFS_CTRL           = 6'h1C;

   // Control field positions
   localparam int          BIT_READ_STROBE    = 0;
   localparam int          BIT_WRITE_STROBE   = 1;
   localparam int          BIT_WRITE_ARM      = 2;
   localparam int          BIT_READY_IRQ_EN   = 3;

   // Reset values
   localparam logic [10:0] ADDR_RESET         = 11'h000;
   localparam logic [7:0]  DATA_RESET         = 8'h00;
   localparam logic        IRQ_EN_RESET       = 1'b0;

   // Cycle counts on the register clock
   localparam logic [2:0]  ARM_CYCLES         = 3'h4;
   localparam logic [2:0]  WRITE_STALL_CYCLES = 3'h2;
   localparam logic [2:0]  READ_STALL_CYCLES  = 3'h4;
endpackage

// ### hw/nvm_timer_if.sv
/*
 * Carrier between the access controller and its write timer.
 * Assumes all three signals live on the register clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface nvm_timer_if;
   logic start;     // One-cycle request to begin a write
   logic osc_tick;  // One pulse per oscillator rising edge
   logic busy;      // Write in progress

   modport ctrl  (output start, output osc_tick, input busy);
   modport timer (input start, input osc_tick, output busy);
endinterface
`default_nettype wire

// ### hw/osc_edge_sync.sv
/*
 * Brings the free-running timing oscillator into the register clock
 * domain and emits one pulse per rising edge.
 * Assumes the oscillator is much slower than the register clock.
 */
`timescale 1ns/1ps
`default_nettype none
module osc_edge_sync (
   input  wire logic clk_i,
   input  wire logic por_n_i,
   input  wire logic osc_i,
   output var  logic tick_o
);
   logic [2:0] chain;
   logic       level;
   logic [2:0] next_chain;
   logic       next_level;
   logic       next_tick;

   // Shift chain, level moves only when stages two and three agree
   always_comb begin
      next_chain = {chain[1:0], osc_i};
      next_level = level;
      next_tick  = 1'b0;
      if (chain[1] == chain[2]) begin
         next_level = chain[2];
         next_tick  = chain[2] & ~level;
      end
   end

   always_ff @(posedge clk_i or negedge por_n_i) begin
      if (!por_n_i) begin
         chain  <= 3'h0;
         level  <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         chain  <= next_chain;
         level  <= next_level;
         tick_o <= next_tick;
      end
   end
endmodule
`default_nettype wire

// ### hw/nvm_write_timer.sv
/*
 * Self-timed write duration counter, counting oscillator ticks.
 * Assumes power-on reset only, so system resets do not abort a write.
 */
`timescale 1ns/1ps
`default_nettype none
module nvm_write_timer
   import nvm_ctrl_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_OSC_CYCLES
) (
   input  wire logic    clk_i,
   input  wire logic    por_n_i,
   nvm_timer_if.timer   tmr
);
   logic [WTIMER_W-1:0] cnt;
   logic                busy;
   logic [WTIMER_W-1:0] next_cnt;
   logic                next_busy;

   // Count ticks from start until the write time has passed
   always_comb begin
      next_cnt  = cnt;
      next_busy = busy;
      if (!busy && tmr.start) begin
         next_busy = 1'b1;
         next_cnt  = '0;
      end else if (busy && tmr.osc_tick) begin
         if (cnt == WTIMER_W'(WRITE_CYCLES - 1)) begin
            next_busy = 1'b0;
         end
         next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge por_n_i) begin
      if (!por_n_i) begin
         cnt  <= '0;
         busy <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         busy <= next_busy;
      end
   end

   assign tmr.busy = busy;

   AST_WRITE_LENGTH: assert property (@(posedge clk_i) disable iff (!por_n_i)
      (busy && tmr.osc_tick && cnt == WTIMER_W'(WRITE_CYCLES - 1)) |=> !busy)
      else $error("write did not end after the full tick count");
   AST_WRITE_NOT_EARLY: assert property (@(posedge clk_i) disable iff (!por_n_i)
      (busy && cnt < WTIMER_W'(WRITE_CYCLES - 1)) |=> busy)
      else $error("write ended before the full tick count");
endmodule
`default_nettype wire

// ### hw/eeprom_byte_access_ctrl.sv
/*
 * Byte access controller between the CPU I/O registers and the data
 * EEPROM array: armed self-timed writes, stalled reads, ready interrupt.
 * Assumes a combinational array read port and a 1 MHz oscillator pin.
 */
`timescale 1ns/1ps
`default_nettype none
module eeprom_byte_access_ctrl
   import nvm_ctrl_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_OSC_CYCLES
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  por_n_i,
   input  wire logic [IO_ADDR_W-1:0]  io_addr_i,
   input  wire logic [7:0]            io_wdata_i,
   input  wire logic                  io_we_i,
   input  wire logic                  io_re_i,
   output var  logic [7:0]            io_rdata_o,
   input  wire logic                  global_irq_enable_i,
   input  wire logic                  selfprog_active_i,
   input  wire logic                  power_down_i,
   input  wire logic                  osc_i,
   output var  logic                  ready_irq_o,
   output var  logic                  cpu_stall_o,
   output var  logic                  osc_keep_o,
   output var  logic [NVM_ADDR_W-1:0] ee_addr_o,
   output var  logic [7:0]            ee_wdata_o,
   output var  logic                  ee_prog_o,
   input  wire logic [7:0]            ee_rdata_i
);
   nvm_timer_if tmr ();

   // Register state
   logic [NVM_ADDR_W-1:0] addr;
   logic [7:0]            data;
   logic                  ready_irq_enable;
   logic                  master_write_arm;
   logic [2:0]            arm_cnt;
   logic [2:0]            stall_cnt;
   logic [7:0]            rdata;
   logic [NVM_ADDR_W-1:0] next_addr;
   logic [7:0]            next_data;
   logic                  next_ready_irq_enable;
   logic                  next_master_write_arm;
   logic [2:0]            next_arm_cnt;
   logic [2:0]            next_stall_cnt;
   logic [7:0]            next_rdata;

   // Write capture state, kept across system reset
   logic [NVM_ADDR_W-1:0] lat_addr;
   logic [7:0]            lat_data;
   logic [NVM_ADDR_W-1:0] next_lat_addr;
   logic [7:0]            next_lat_data;

   // Oscillator hold for a power-down that met a running write
   logic                  osc_hold;
   logic                  next_osc_hold;

   // Decoded accesses
   logic                  wr_ctrl;
   logic                  wr_hi;
   logic                  wr_lo;
   logic                  wr_data;
   logic                  write_busy;
   logic                  start_write;
   logic                  start_read;
   logic                  arm_request;

   assign write_busy  = tmr.busy;
   assign wr_ctrl     = io_we_i && (io_addr_i == OFS_CTRL);
   assign wr_hi       = io_we_i && (io_addr_i == OFS_ADDR_HI);
   assign wr_lo       = io_we_i && (io_addr_i == OFS_ADDR_LO);
   assign wr_data     = io_we_i && (io_addr_i == OFS_DATA);
   assign arm_request = wr_ctrl && io_wdata_i[BIT_WRITE_ARM]
                        && !io_wdata_i[BIT_WRITE_STROBE];

   // Write start needs a live arm, no flash write, no write running
   assign start_write = wr_ctrl && io_wdata_i[BIT_WRITE_STROBE]
                        && master_write_arm
                        && !selfprog_active_i
                        && !write_busy;
   // Read is blocked while a write runs or is being started
   assign start_read  = wr_ctrl && io_wdata_i[BIT_READ_STROBE]
                        && !write_busy && !start_write;

   // Oscillator edges into the register domain
   osc_edge_sync u_sync (
      .clk_i   (clk_i),
      .por_n_i (por_n_i),
      .osc_i   (osc_i),
      .tick_o  (tmr.osc_tick)
   );

   // Self-timed write counter on power-on reset only
   nvm_write_timer #(
      .WRITE_CYCLES (WRITE_CYCLES)
   ) u_timer (
      .clk_i   (clk_i),
      .por_n_i (por_n_i),
      .tmr     (tmr)
   );

   assign tmr.start = start_write;

   // Next values of software-visible registers
   always_comb begin
      next_addr             = addr;
      next_data             = data;
      next_ready_irq_enable = ready_irq_enable;
      next_master_write_arm = master_write_arm;
      next_arm_cnt          = arm_cnt;
      next_stall_cnt        = stall_cnt;
      next_rdata            = rdata;
      // Address writes ignored during a write
      if (wr_hi && !write_busy) begin
         next_addr[NVM_ADDR_W-1:8] = io_wdata_i[NVM_ADDR_W-9:0];
      end
      if (wr_lo && !write_busy) begin
         next_addr[7:0] = io_wdata_i;
      end
      if (wr_data) begin
         next_data = io_wdata_i;
      end
      if (wr_ctrl) begin
         next_ready_irq_enable = io_wdata_i[BIT_READY_IRQ_EN];
      end
      // Arm window counts down and drops after four cycles
      if (arm_cnt != 3'h0) begin
         next_arm_cnt = arm_cnt - 3'h1;
         if (arm_cnt == 3'h1) begin
            next_master_write_arm = 1'b0;
         end
      end
      if (arm_request) begin
         next_master_write_arm = 1'b1;
         next_arm_cnt          = ARM_CYCLES;
      end
      if (start_write) begin
         next_master_write_arm = 1'b0;
         next_arm_cnt          = 3'h0;
      end
      // CPU stall counter
      if (stall_cnt != 3'h0) begin
         next_stall_cnt = stall_cnt - 3'h1;
      end
      if (start_write) begin
         next_stall_cnt = WRITE_STALL_CYCLES;
      end else if (start_read) begin
         next_stall_cnt = READ_STALL_CYCLES;
         next_data      = ee_rdata_i;
      end
      // Registered read-back
      case (io_addr_i)
         OFS_ADDR_HI: next_rdata = {5'h00, addr[NVM_ADDR_W-1:8]};
         OFS_ADDR_LO: next_rdata = addr[7:0];
         OFS_DATA:    next_rdata = data;
         OFS_CTRL:    next_rdata = {4'h0, ready_irq_enable, master_write_arm,
                                    write_busy, 1'b0};
         default:     next_rdata = 8'h00;
      endcase
      if (!io_re_i) begin
         next_rdata = rdata;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr             <= ADDR_RESET;
         data             <= DATA_RESET;
         ready_irq_enable <= IRQ_EN_RESET;
         master_write_arm <= 1'b0;
         arm_cnt          <= 3'h0;
         stall_cnt        <= 3'h0;
         rdata            <= 8'h00;
      end else begin
         addr             <= next_addr;
         data             <= next_data;
         ready_irq_enable <= next_ready_irq_enable;
         master_write_arm <= next_master_write_arm;
         arm_cnt          <= next_arm_cnt;
         stall_cnt        <= next_stall_cnt;
         rdata            <= next_rdata;
      end
   end

   // Capture of address and data at write start
   always_comb begin
      next_lat_addr = lat_addr;
      next_lat_data = lat_data;
      if (start_write) begin
         next_lat_addr = addr;
         next_lat_data = data;
      end
   end

   // Power-on reset only, so a running write survives system reset
   always_ff @(posedge clk_i or negedge por_n_i) begin
      if (!por_n_i) begin
         lat_addr <= ADDR_RESET;
         lat_data <= DATA_RESET;
      end else begin
         lat_addr <= next_lat_addr;
         lat_data <= next_lat_data;
      end
   end

   // Oscillator stays on for the rest of a power-down that saw a write
   always_comb begin
      next_osc_hold = osc_hold;
      if (power_down_i && write_busy) begin
         next_osc_hold = 1'b1;
      end
      if (!power_down_i) begin
         next_osc_hold = 1'b0;
      end
   end

   // Power-on reset only, like the write it follows
   always_ff @(posedge clk_i or negedge por_n_i) begin
      if (!por_n_i) begin
         osc_hold <= 1'b0;
      end else begin
         osc_hold <= next_osc_hold;
      end
   end

   // Array side and CPU-facing outputs
   assign ee_addr_o   = write_busy ? lat_addr : addr;
   assign ee_wdata_o  = lat_data;
   assign ee_prog_o   = write_busy;
   assign osc_keep_o  = write_busy || osc_hold;
   assign cpu_stall_o = (stall_cnt != 3'h0);
   assign io_rdata_o  = rdata;
   assign ready_irq_o = ready_irq_enable && global_irq_enable_i
                        && !write_busy;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence arm_set_s;
      arm_request;
   endsequence
   sequence arm_quiet_s;
      (!arm_request && !start_write) [*4];
   endsequence
   sequence write_stall_s;
      cpu_stall_o [*2] ##1 !cpu_stall_o;
   endsequence
   sequence read_stall_s;
      cpu_stall_o [*4] ##1 !cpu_stall_o;
   endsequence

   AST_ARM_TIMEOUT: assert property (
      arm_set_s ##1 arm_quiet_s |=> !master_write_arm)
      else $error("arm bit did not clear after four cycles");
   AST_ARM_LIVE: assert property (
      arm_set_s |=> (master_write_arm || ee_prog_o) [*4])
      else $error("arm bit dropped inside its window");
   AST_START_ARMED: assert property (
      (wr_ctrl && io_wdata_i[BIT_WRITE_STROBE] && master_write_arm
       && !selfprog_active_i && !write_busy) |=> ee_prog_o && cpu_stall_o)
      else $error("armed strobe did not start a write");
   AST_UNARMED_IGNORED: assert property (
      (wr_ctrl && !master_write_arm && !write_busy) |=> !ee_prog_o)
      else $error("write started without arm");
   AST_SELFPROG_BLOCK: assert property (
      (selfprog_active_i && !write_busy) |=> !ee_prog_o)
      else $error("write started during flash programming");
   AST_WRITE_STALL: assert property (
      start_write |=> write_stall_s)
      else $error("write stall not two cycles");
   AST_READ_STALL: assert property (
      start_read |=> read_stall_s)
      else $error("read stall not four cycles");
   AST_READ_DATA: assert property (
      start_read |=> data == $past(ee_rdata_i))
      else $error("read data not loaded");
   AST_ADDR_LOCK: assert property (
      (write_busy && (wr_hi || wr_lo)) |=> $stable(addr))
      else $error("address changed during a write");
   AST_IRQ_ON_DONE: assert property (
      ($fell(write_busy) && ready_irq_enable && global_irq_enable_i) |-> ready_irq_o)
      else $error("ready interrupt missing after write");
   AST_CAPTURE_HOLD: assert property (
      (write_busy && $past(write_busy)) |-> $stable(ee_addr_o) && $stable(ee_wdata_o))
      else $error("array address or data moved during write");
   AST_OSC_KEEP: assert property (
      (power_down_i && write_busy) |=> (osc_keep_o || !power_down_i))
      else $error("oscillator released during power-down after a write");
   AST_OSC_IDLE: assert property (
      (!power_down_i && !write_busy) |=> (!osc_keep_o || write_busy))
      else $error("oscillator held with no write and no power-down");
endmodule
`default_nettype wire

// ### dv/eeprom_array_model.sv
/*
 * Behavioural data EEPROM array facing the access controller.
 * Assumes the program enable stays high for the whole write.
 */
`timescale 1ns/1ps
`default_nettype none
module eeprom_array_model (
   input  wire logic        clk_i,
   input  wire logic [10:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        prog_i,
   output var  logic [7:0]  rdata_o
);
   logic [7:0]  mem [2048];
   logic [10:0] wa;
   logic [7:0]  wd;
   logic        prog_q;
   logic [7:0]  junk;

   // Known start contents, mirrored by the bench
   initial begin
      for (int i = 0; i < 2048; i++) begin
         mem[i] = 8'((i * 37 + 11) ^ (i >> 8));
      end
      prog_q = 1'b0;
      junk   = 8'h5A;
   end

   // Track the byte being programmed, commit it when programming ends
   always @(posedge clk_i) begin
      junk   <= ~junk;
      prog_q <= prog_i;
      if (prog_i) begin
         wa <= addr_i;
         wd <= wdata_i;
      end
      if (prog_q && !prog_i) begin
         mem[wa] <= wd;
      end
   end

   // Read port shows a changing pattern while programming
   assign rdata_o = prog_i ? junk : mem[addr_i];
endmodule
`default_nettype wire

// ### dv/eeprom_byte_access_ctrl_tb.sv
/*
 * Self-checking bench for the byte access controller with an array model.
 * Assumes a fast timing oscillator and a shortened write count.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
   $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module eeprom_byte_access_ctrl_tb;
   import nvm_ctrl_pkg::*;
   localparam int WC    = 4;
   localparam int LIMIT = 6000;
   logic        clk, rst_n, por_n, we, re, gie, spa, pdn, osc;
   logic        irq, stall, keep, prog;
   logic [5:0]  addr;
   logic [7:0]  wdata, rdata, ewd, erd, v, ie;
   logic [10:0] ea;
   int          mismatches, comparisons, cyc, st, n, a, d, ws;
   int          mm [int];

   eeprom_byte_access_ctrl #(.WRITE_CYCLES(WC)) eeprom_byte_access_ctrl_i (
      .clk_i(clk), .rst_n_i(rst_n), .por_n_i(por_n), .io_addr_i(addr),
      .io_wdata_i(wdata), .io_we_i(we), .io_re_i(re), .io_rdata_o(rdata),
      .global_irq_enable_i(gie), .selfprog_active_i(spa), .power_down_i(pdn),
      .osc_i(osc), .ready_irq_o(irq), .cpu_stall_o(stall), .osc_keep_o(keep),
      .ee_addr_o(ea), .ee_wdata_o(ewd), .ee_prog_o(prog), .ee_rdata_i(erd));
   eeprom_array_model eeprom_array_model_i (
      .clk_i(clk), .addr_i(ea), .wdata_i(ewd), .prog_i(prog), .rdata_o(erd));

   // Register clock and free-running timing oscillator
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      osc = 1'b0;
      #7;
      forever #125 osc = ~osc;
   end

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         mismatches++;
         test_done();
      end
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Expected array byte from the bench's own record
   function automatic logic [7:0] expb(int x);
      return mm.exists(x) ? 8'(mm[x]) : 8'((x * 37 + 11) ^ (x >> 8));
   endfunction

   task automatic idle(int k);
      repeat (k) @(posedge clk) #1;
   endtask

   // Register write; st counts stall cycles that follow it
   task automatic io_wr(input logic [5:0] ad, input logic [7:0] dt);
      addr  = ad;
      wdata = dt;
      we    = 1'b1;
      @(posedge clk) #1;
      we = 1'b0;
      st = 0;
      while (stall === 1'b1 && st < 10) begin
         st++;
         @(posedge clk) #1;
      end
      @(posedge clk) #1;
   endtask

   task automatic io_rd(input logic [5:0] ad);
      addr = ad;
      re   = 1'b1;
      @(posedge clk) #1;
      re = 1'b0;
      v  = rdata;
      @(posedge clk) #1;
   endtask

   task automatic set_addr(int x);
      io_wr(OFS_ADDR_HI, 8'(x >> 8));
      io_wr(OFS_ADDR_LO, 8'(x));
   endtask

   // Triggered read, compared with the model
   // Poll the strobe bit until no write runs
   task automatic wait_idle();
      io_rd(OFS_CTRL);
      while (v[BIT_WRITE_STROBE] !== 1'b0 && cyc < LIMIT) begin
         io_rd(OFS_CTRL);
      end
   endtask

   task automatic ee_read(int x);
      wait_idle();
      set_addr(x);
      io_wr(OFS_CTRL, 8'h01);
      `CHK("read stall", 4, st)
      io_rd(OFS_DATA);
      `CHK("read data", expb(x), v)
   endtask

   // Load, arm, strobe after a gap; ok says whether a write must start
   task automatic ee_write(int x, int y, int gap, bit ok);
      wait_idle();
      set_addr(x);
      io_wr(OFS_DATA, 8'(y));
      io_wr(OFS_CTRL, 8'h04 | ie);
      idle(gap);
      io_wr(OFS_CTRL, 8'h02 | ie);
      ws = cyc;
      `CHK("write stall", ok ? 2 : 0, st)
      `CHK("prog", ok, prog)
      if (ok) mm[x] = y;
   endtask

   // Wait out programming and check its length in clocks since the strobe returned
   task automatic wait_done();
      while (prog === 1'b1 && cyc - ws < 200) begin
         @(posedge clk) #1;
      end
      n = cyc - ws;
      `CHK("write length", 1'b1, (n >= WC * 10 - 14 && n <= WC * 10 + 6))
   endtask

   // Main sequence
   initial begin
      void'($urandom(19162));
      {rst_n, por_n, we, re, gie, spa, pdn} = '0;
      {addr, wdata, ie} = '0;
      {mismatches, comparisons, cyc} = '0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      por_n = 1'b1;
      idle(4);
      // Reset values, reserved bits, unmapped offset
      io_rd(OFS_CTRL);
      `CHK("ctrl reset", 8'h00, v)
      io_rd(6'h00);
      `CHK("unmapped", 8'h00, v)
      io_wr(OFS_ADDR_HI, 8'hFF);
      io_rd(OFS_ADDR_HI);
      `CHK("addr high", 8'h07, v)
      io_wr(OFS_CTRL, 8'hF0);
      io_rd(OFS_CTRL);
      `CHK("ctrl upper", 8'h00, v)
      // Arm bit lives four cycles
      io_wr(OFS_CTRL, 8'h04);
      io_rd(OFS_CTRL);
      `CHK("arm set", 8'h04, v)
      idle(1);
      io_rd(OFS_CTRL);
      `CHK("arm expired", 8'h00, v)
      ee_read($urandom_range(0, 2047));
      ee_read(2047);
      // Writes in the second and the last cycle of the arm window, with read-back
      for (int i = 0; i < 4; i++) begin
         a = (i == 3) ? 2047 : $urandom_range(0, 2047);
         d = $urandom_range(0, 255);
         ee_write(a, d, (i % 2) * 2, 1);
         wait_done();
         ee_read(a);
      end
      ee_write($urandom_range(0, 2047), 8'hC3, 3, 0);
      set_addr(5);
      io_wr(OFS_CTRL, 8'h02);
      `CHK("unarmed", 1'b0, prog)
      spa = 1'b1;
      ee_write(6, 8'h3C, 0, 0);
      spa = 1'b0;
      ee_read(6);
      // Ready interrupt gating
      io_wr(OFS_CTRL, 8'h08);
      `CHK("irq no gie", 1'b0, irq)
      gie = 1'b1;
      idle(1);
      `CHK("irq on", 1'b1, irq)
      io_wr(OFS_CTRL, 8'h00);
      `CHK("irq off", 1'b0, irq)
      // Busy write with the interrupt enabled: interference, power-down, reset
      ie  = 8'h08;
      gie = 1'b0;
      a = $urandom_range(0, 2047);
      d = $urandom_range(0, 255);
      ee_write(a, d, 1, 1);
      gie = 1'b1;
      idle(1);
      `CHK("irq busy", 1'b0, irq)
      io_rd(OFS_CTRL);
      `CHK("ctrl busy", 8'h0A, v)
      pdn = 1'b1;
      idle(1);
      `CHK("osc keep", 1'b1, keep)
      io_wr(OFS_DATA, 8'(~d));
      io_wr(OFS_ADDR_LO, 8'(~a));
      io_rd(OFS_ADDR_LO);
      `CHK("addr locked", 8'(a), v)
      io_wr(OFS_CTRL, 8'h09);
      `CHK("blocked stall", 0, st)
      io_rd(OFS_DATA);
      `CHK("read blocked", 8'(~d), v)
      idle(1);
      `CHK("irq level", 1'b0, irq)
      rst_n = 1'b0;
      idle(2);
      rst_n = 1'b1;
      idle(1);
      `CHK("survives reset", 1'b1, prog)
      io_wr(OFS_CTRL, 8'h08);
      wait_done();
      `CHK("irq done", 1'b1, irq)
      `CHK("osc held", 1'b1, keep)
      pdn = 1'b0;
      idle(1);
      `CHK("osc released", 1'b0, keep)
      io_rd(OFS_CTRL);
      `CHK("strobe cleared", 8'h08, v)
      wait_idle();
      pdn = 1'b1;
      idle(1);
      `CHK("keep idle", 1'b0, keep)
      pdn = 1'b0;
      ee_read(a);
      test_done();
   end
endmodule
`default_nettype wire
